// ### bench/epv_vec_mem_model.sv
// Vector table memory model answering the block's fetch port
module epv_vec_mem_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Fetch port
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ack,
    output logic [31:0] fetch_data,
    // Wait cycles before each answer
    input wire logic [3:0] ack_delay
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] wait_q;

    // ************************************************************
    // Table word is a scramble of its address
    // ************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_q <= 4'h0;
            fetch_ack <= 1'b0;
            fetch_data <= 32'h3C3C3C3C;
        end else begin
            fetch_ack <= 1'b0;
            fetch_data <= ~fetch_data;
            if (fetch_req && !fetch_ack) begin
                if (wait_q == ack_delay) begin
                    wait_q <= 4'h0;
                    fetch_ack <= 1'b1;
                    fetch_data <= fetch_addr ^ 32'h5A5A0F0F;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule : epv_vec_mem_model

// ### bench/exception_priority_vector_select_tb.sv
// Self-checking bench for the exception priority and vector select block
module exception_priority_vector_select_tb;
    import epv_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, resetn, fetch_req, fetch_ack, handler_valid, handler_fast, handler_ack;
    logic [7:0] src, irq_vec, trap_num, handler_vec;
    logic [3:0] irq_level, ack_delay;
    logic [31:0] base, fvt, fetch_addr, fetch_data, handler_addr;
    epv_cause_e handler_cause;
    int num_errors, total_checks, cycles;

    epv_select u_epv_select (.sys_clk(sys_clk), .resetn(resetn), .nmi_req(src[0]),
        .irq_req(src[1]), .irq_vec(irq_vec), .irq_level(irq_level), .iacc_fault(src[2]),
        .undef_insn(src[3]), .priv_insn(src[4]), .trap_req(src[5]), .trap_num(trap_num),
        .oacc_fault(src[6]), .fpu_fault(src[7]), .relocatable_table_base(base),
        .fast_vector_target(fvt), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_ack(fetch_ack), .fetch_data(fetch_data), .handler_valid(handler_valid),
        .handler_addr(handler_addr), .handler_cause(handler_cause),
        .handler_vec(handler_vec), .handler_fast(handler_fast), .handler_ack(handler_ack));

    epv_vec_mem_model u_epv_vec_mem_model (.sys_clk(sys_clk), .resetn(resetn),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .ack_delay(ack_delay));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] fx(input logic [4:0] i);
        return EPV_FIXED_BASE + {25'h0, i, 2'b00};
    endfunction : fx

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Waits for one handler, checks it, drops its source and acks it
    task automatic take(input epv_cause_e c, input logic [31:0] fa, input logic fast,
                        input logic [7:0] vec, input logic [7:0] clr);
        int n;
        logic saw;
        n = 0;
        saw = 1'b0;
        while (handler_valid !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
            if (fetch_req === 1'b1 && !saw) begin
                saw = 1'b1;
                chk(fetch_addr, fa);
            end
        end
        chk(32'(handler_cause), 32'(c));
        chk(32'(handler_vec), 32'(vec));
        chk(32'(handler_fast), 32'(fast));
        chk(32'(saw), 32'(!fast));
        chk(handler_addr, fast ? fvt : (fa ^ 32'h5A5A0F0F));
        src = src & ~clr;
        handler_ack = 1'b1;
        @(negedge sys_clk);
        handler_ack = 1'b0;
        chk(32'(handler_valid), 32'h0);
    endtask : take

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_priority();
        base = 32'h00001000;
        irq_vec = 8'h07;
        irq_level = 4'h3;
        trap_num = 8'hFF;
        ack_delay = 4'h0;
        src = 8'hFF;
        take(EPV_C_NMI, fx(EPV_IDX_NMI), 1'b0, 8'h00, 8'h01);
        take(EPV_C_IRQ, 32'h0000101C, 1'b0, 8'h07, 8'h02);
        take(EPV_C_IACC, fx(EPV_IDX_IACC), 1'b0, 8'h00, 8'h04);
        take(EPV_C_UNDEF, fx(EPV_IDX_UNDEF), 1'b0, 8'h00, 8'h08);
        take(EPV_C_PRIV, fx(EPV_IDX_PRIV), 1'b0, 8'h00, 8'h10);
        take(EPV_C_TRAP, 32'h000013FC, 1'b0, 8'hFF, 8'h20);
        take(EPV_C_OACC, fx(EPV_IDX_OACC), 1'b0, 8'h00, 8'h40);
        take(EPV_C_FPU, fx(EPV_IDX_FPU), 1'b0, 8'h00, 8'h80);
    endtask : t_priority

    task automatic t_fast_and_moves();
        ack_delay = 4'h5;
        fvt = 32'h00008000;
        irq_vec = 8'h20;
        irq_level = 4'hF;
        src = 8'h02;
        take(EPV_C_IRQ, 32'h0, 1'b1, 8'h20, 8'h02);
        irq_level = 4'hE;
        irq_vec = 8'h00;
        base = 32'hFFFF0000;
        trap_num = 8'h01;
        src = 8'h22;
        take(EPV_C_IRQ, 32'hFFFF0000, 1'b0, 8'h00, 8'h02);
        take(EPV_C_TRAP, 32'hFFFF0004, 1'b0, 8'h01, 8'h20);
        src = 8'h80;
        take(EPV_C_FPU, fx(EPV_IDX_FPU), 1'b0, 8'h00, 8'h80);
    endtask : t_fast_and_moves

    // ************************************************************
    // Clock, timeout and main sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        {resetn, handler_ack, src, irq_vec, trap_num, irq_level} = '0;
        {base, fvt, ack_delay} = '0;
        num_errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (4) @(negedge sys_clk);
        resetn = 1'b1;
        take(EPV_C_RESET, EPV_RESET_ADDR, 1'b0, 8'h00, 8'h00);
        t_priority();
        t_fast_and_moves();
        report_and_stop();
    end
endmodule : exception_priority_vector_select_tb

// ### hdl/epv_select.sv
// Exception arbitration and handler address selection
// Notes on behaviour
// - Winner order: reset, NMI, interrupt, instr access, undef/priv, trap, operand, FPU.
// - No ranking among interrupts; take the one request the controller presents.
// - System exceptions, reset included, use a fixed table no register can move.
// - Interrupts and traps use the relocatable table at its base; entries 0 to 255.
// - Fast interrupt jumps to the fast vector target with no table read.
// - Fixed table starts at FFFFFF80h; reset address sits in its last entry.
// - An interrupt at level 15 is a fast interrupt.
module epv_select
    import epv_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Exception sources
    input wire logic nmi_req,
    input wire logic irq_req,
    input wire logic [EPV_VEC_W-1:0] irq_vec,
    input wire logic [3:0] irq_level,
    input wire logic iacc_fault,
    input wire logic undef_insn,
    input wire logic priv_insn,
    input wire logic trap_req,
    input wire logic [EPV_VEC_W-1:0] trap_num,
    input wire logic oacc_fault,
    input wire logic fpu_fault,
    // Control register values
    input wire logic [31:0] relocatable_table_base,
    input wire logic [31:0] fast_vector_target,
    // Vector fetch port
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic fetch_ack,
    input wire logic [31:0] fetch_data,
    // Handler answer to the pipeline
    output logic handler_valid,
    output logic [31:0] handler_addr,
    output epv_cause_e handler_cause,
    output logic [EPV_VEC_W-1:0] handler_vec,
    output logic handler_fast,
    input wire logic handler_ack
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        epv_state_e state;
        logic rst_pend;
        epv_cause_e cause;
        logic [EPV_VEC_W-1:0] vec;
        logic fast;
        logic fetch_req;
        logic [31:0] fetch_addr;
        logic handler_valid;
        logic [31:0] handler_addr;
    } epv_st_s;

    epv_st_s st_q;
    epv_st_s st_d;

    logic idle;
    logic win_nmi;
    logic win_irq;
    logic win_iacc;
    logic win_trap;
    logic win_fpu;

    // ************************************************************
    // Winner flags
    // ************************************************************
    assign idle = (st_q.state == EPV_IDLE);
    assign win_nmi = idle && !st_q.rst_pend && nmi_req;
    assign win_irq = idle && !st_q.rst_pend && !nmi_req && irq_req;
    assign win_iacc = idle && !st_q.rst_pend && !nmi_req && !irq_req && iacc_fault;
    assign win_trap = idle && !st_q.rst_pend && !nmi_req && !irq_req && !iacc_fault
        && !undef_insn && !priv_insn && trap_req;
    assign win_fpu = idle && !st_q.rst_pend && !nmi_req && !irq_req && !iacc_fault
        && !undef_insn && !priv_insn && !trap_req && !oacc_fault && fpu_fault;

    function automatic logic [31:0] fixed_entry(input logic [EPV_FIXED_IDX_W-1:0] idx);
        fixed_entry = EPV_FIXED_BASE + {25'h0000000, idx, 2'h0};
    endfunction : fixed_entry

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic take;
        logic reloc;
        logic [EPV_FIXED_IDX_W-1:0] idx;
        take = 1'b1;
        reloc = 1'b0;
        idx = EPV_IDX_RESET;
        st_d = st_q;
        case (st_q.state)
            EPV_IDLE: begin
                st_d.fast = 1'b0;
                if (st_q.rst_pend) begin
                    st_d.cause = EPV_C_RESET;
                    idx = EPV_IDX_RESET;
                end else if (nmi_req) begin
                    st_d.cause = EPV_C_NMI;
                    idx = EPV_IDX_NMI;
                end else if (irq_req) begin
                    st_d.cause = EPV_C_IRQ;
                    st_d.vec = irq_vec;
                    reloc = 1'b1;
                    st_d.fast = (irq_level == EPV_FAST_LEVEL);
                end else if (iacc_fault) begin
                    st_d.cause = EPV_C_IACC;
                    idx = EPV_IDX_IACC;
                end else if (undef_insn) begin
                    st_d.cause = EPV_C_UNDEF;
                    idx = EPV_IDX_UNDEF;
                end else if (priv_insn) begin
                    st_d.cause = EPV_C_PRIV;
                    idx = EPV_IDX_PRIV;
                end else if (trap_req) begin
                    st_d.cause = EPV_C_TRAP;
                    st_d.vec = trap_num;
                    reloc = 1'b1;
                end else if (oacc_fault) begin
                    st_d.cause = EPV_C_OACC;
                    idx = EPV_IDX_OACC;
                end else if (fpu_fault) begin
                    st_d.cause = EPV_C_FPU;
                    idx = EPV_IDX_FPU;
                end else begin
                    take = 1'b0;
                end
                if (take) begin
                    st_d.rst_pend = 1'b0;
                    if (!reloc) begin
                        st_d.vec = '0;
                    end
                    if (st_d.fast) begin
                        st_d.handler_addr = fast_vector_target;
                        st_d.handler_valid = 1'b1;
                        st_d.state = EPV_DONE;
                    end else begin
                        if (reloc) begin
                            st_d.fetch_addr = relocatable_table_base
                                + {22'h000000, st_d.vec, 2'h0};
                        end else begin
                            st_d.fetch_addr = fixed_entry(idx);
                        end
                        st_d.fetch_req = 1'b1;
                        st_d.state = EPV_FETCH;
                    end
                end
            end
            EPV_FETCH: begin
                if (fetch_ack) begin
                    st_d.fetch_req = 1'b0;
                    st_d.handler_addr = fetch_data;
                    st_d.handler_valid = 1'b1;
                    st_d.state = EPV_DONE;
                end
            end
            default: begin
                if (handler_ack) begin
                    st_d.handler_valid = 1'b0;
                    st_d.state = EPV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{state: EPV_IDLE, rst_pend: 1'b1, cause: EPV_C_NONE, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign fetch_req = st_q.fetch_req;
    assign fetch_addr = st_q.fetch_addr;
    assign handler_valid = st_q.handler_valid;
    assign handler_addr = st_q.handler_addr;
    assign handler_cause = st_q.cause;
    assign handler_vec = st_q.vec;
    assign handler_fast = st_q.fast;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_fetch_done;
        fetch_req && fetch_ack ##1 handler_valid;
    endsequence

    property p_reset_first;
        @(posedge sys_clk) disable iff (!resetn)
        idle && st_q.rst_pend |=> fetch_req && handler_cause == EPV_C_RESET
            && fetch_addr == EPV_RESET_ADDR;
    endproperty
    a_reset_first: assert property (p_reset_first) else $error("reset not first");

    property p_nmi_over_irq;
        @(posedge sys_clk) disable iff (!resetn)
        win_nmi |=> handler_cause == EPV_C_NMI;
    endproperty
    a_nmi_over_irq: assert property (p_nmi_over_irq) else $error("nmi lost");

    property p_fpu_last;
        @(posedge sys_clk) disable iff (!resetn)
        idle && !win_fpu && fpu_fault && !st_q.rst_pend |=> handler_cause != EPV_C_FPU;
    endproperty
    a_fpu_last: assert property (p_fpu_last) else $error("fpu won early");

    property p_irq_vec;
        @(posedge sys_clk) disable iff (!resetn)
        win_irq |=> handler_cause == EPV_C_IRQ && handler_vec == $past(irq_vec);
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("irq vector mismatch");

    property p_fixed_region;
        @(posedge sys_clk) disable iff (!resetn)
        win_iacc |=> fetch_req && fetch_addr == fixed_entry(EPV_IDX_IACC);
    endproperty
    a_fixed_region: assert property (p_fixed_region) else $error("fixed addr wrong");

    property p_trap_reloc;
        @(posedge sys_clk) disable iff (!resetn)
        win_trap |=> fetch_req && fetch_addr == $past(relocatable_table_base)
            + {22'h000000, $past(trap_num), 2'h0};
    endproperty
    a_trap_reloc: assert property (p_trap_reloc) else $error("trap addr wrong");

    property p_fast_path;
        @(posedge sys_clk) disable iff (!resetn)
        win_irq && irq_level == EPV_FAST_LEVEL |=> handler_valid && !fetch_req
            && handler_addr == $past(fast_vector_target);
    endproperty
    a_fast_path: assert property (p_fast_path) else $error("fast path wrong");

    property p_slow_irq;
        @(posedge sys_clk) disable iff (!resetn)
        win_irq && irq_level != EPV_FAST_LEVEL |=> fetch_req && !handler_fast;
    endproperty
    a_slow_irq: assert property (p_slow_irq) else $error("level decode wrong");

    property p_fetch_result;
        @(posedge sys_clk) disable iff (!resetn)
        fetch_req && fetch_ack |-> s_fetch_done ##0 handler_addr == $past(fetch_data);
    endproperty
    a_fetch_result: assert property (p_fetch_result) else $error("fetch lost");

endmodule : epv_select

// ### pkg/epv_pkg.sv
// Constants and types for the exception priority and vector select block
package epv_pkg;

    // ************************************************************
    // Address map of the vector tables
    // ************************************************************
    localparam logic [31:0] EPV_FIXED_BASE = 32'hFFFFFF80;
    localparam int EPV_ENTRY_SHIFT = 2;
    localparam int EPV_FIXED_IDX_W = 5;
    localparam int EPV_VEC_W = 8;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_RESET = 5'h1F;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_NMI = 5'h1E;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_UNDEF = 5'h18;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_PRIV = 5'h19;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_IACC = 5'h1A;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_OACC = 5'h1B;
    localparam logic [EPV_FIXED_IDX_W-1:0] EPV_IDX_FPU = 5'h1C;
    localparam logic [31:0] EPV_RESET_ADDR = 32'hFFFFFFFC;

    // ************************************************************
    // Interrupt level that selects the fast path
    // ************************************************************
    localparam logic [3:0] EPV_FAST_LEVEL = 4'hF;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        EPV_IDLE,
        EPV_FETCH,
        EPV_DONE
    } epv_state_e;

    typedef enum logic [3:0] {
        EPV_C_NONE,
        EPV_C_RESET,
        EPV_C_NMI,
        EPV_C_IRQ,
        EPV_C_IACC,
        EPV_C_UNDEF,
        EPV_C_PRIV,
        EPV_C_TRAP,
        EPV_C_OACC,
        EPV_C_FPU
    } epv_cause_e;

endpackage : epv_pkg
